//--- exp_model.sv
`timescale 1ns/1ns
module exp_model #(parameter N = 4) (
    input wire scl,
    input wire sda,
    input wire [3:0] change,
    output reg sda_pull,
    output reg irq_n
);
    reg [3:0] pend = 4'h0;
    reg [7:0] addr;
    reg [7:0] dat;
    reg [2:0] idx;
    reg hit;
    integer k;
    // A status change holds the shared line low until that expander is read
    always @(change) pend = pend | change;
    always @* irq_n = ~|pend;
    // Slave byte engine; the line floats back to the pull-up when released
    initial
    begin
        sda_pull = 1'b0;
        forever
        begin
            @(negedge sda iff (scl === 1'b1));
            for (k = 7; k >= 0; k = k - 1)
            begin
                @(posedge scl);
                addr[k] = sda;
            end
            @(negedge scl);
            idx = addr[3:1];
            hit = addr[7:4] == 4'h4 && addr[0] && idx < N;
            dat = 8'h5a ^ {5'h00, idx};
            sda_pull = hit;
            for (k = 8; k >= 0; k = k - 1)
            begin
                @(negedge scl);
                sda_pull = hit && k > 0 && !dat[k-1];
            end
            if (hit) pend[idx] = 1'b0;
        end
    end
endmodule // exp_model

//--- misc_pin_chk.sv
`timescale 1ns/1ns
module misc_pin_chk #(parameter NUM_EXP = 4) (
    input wire mclk,
    input wire rst_n,
    input wire hotplug_scl_out,
    input wire hotplug_scl_oe,
    input wire hotplug_sda_out,
    input wire hotplug_sda_oe,
    input wire hotplug_irq_n,
    input wire exp_status_valid,
    input wire [2:0] exp_status_idx,
    input wire [7:0] gpio_oe,
    input wire [7:0] gpio_oe_ctrl,
    input wire [4:0] debug_status_out,
    input wire [4:0] debug_status_oe,
    input wire [4:0] debug_status_int,
    input wire [1:0] port_lane_cfg,
    input wire [2:0] op_mode_strap,
    input wire [3:0] upstream_port_strap,
    input wire i2c_mode,
    input wire debug_mode,
    input wire straps_valid
);
    // One clock domain, so clock and reset are shared by every check
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Open drain only ever pulls, and the shared lines stay free until straps are in
    a_scl_open_drain: assert property (hotplug_scl_out == 1'b0
        && (straps_valid || !hotplug_scl_oe)) else $error("clock pin driven high");
    a_sda_open_drain: assert property (hotplug_sda_out == 1'b0
        && (straps_valid || !hotplug_sda_oe)) else $error("data pin driven high");
    a_irq_starts_read: assert property ($fell(hotplug_irq_n) && straps_valid
        && !hotplug_sda_oe |-> ##[1:40] hotplug_sda_oe) else $error("no read on interrupt");
    a_valid_one_cycle: assert property (exp_status_valid |=> !exp_status_valid)
        else $error("status pulse too long");
    a_idx_in_range: assert property (exp_status_valid |-> exp_status_idx < NUM_EXP)
        else $error("expander index out of range");
    a_oe_wait_straps: assert property (!straps_valid |-> gpio_oe == 8'h00
        && debug_status_oe == 5'h00) else $error("pin driven before capture");
    a_straps_held: assert property (straps_valid && $past(straps_valid) |->
        $stable({port_lane_cfg, op_mode_strap, upstream_port_strap, i2c_mode}))
        else $error("strap value moved");
    a_cfg_defined: assert property (port_lane_cfg != 2'h3)
        else $error("undefined lane config");
    a_debug_mode: assert property (straps_valid && $past(straps_valid) |->
        debug_mode == (op_mode_strap != 3'h0)) else $error("debug mode wrong");
    a_gpio_oe_ctrl: assert property (straps_valid && $stable(gpio_oe_ctrl) [*6] |->
        gpio_oe == gpio_oe_ctrl) else $error("gpio enable wrong");
    a_debug_out: assert property (straps_valid && $stable(debug_status_int) [*6] |->
        debug_status_out == debug_status_int && debug_status_oe == 5'h1f)
        else $error("debug output wrong");
endmodule // misc_pin_chk
bind strap_and_misc_pin_control misc_pin_chk #(.NUM_EXP(NUM_EXP)) u_chk (.mclk, .rst_n,
    .hotplug_scl_out, .hotplug_scl_oe, .hotplug_sda_out, .hotplug_sda_oe, .hotplug_irq_n,
    .exp_status_valid,
    .exp_status_idx, .gpio_oe, .gpio_oe_ctrl, .debug_status_out, .debug_status_oe,
    .debug_status_int, .port_lane_cfg, .op_mode_strap, .upstream_port_strap, .i2c_mode,
    .debug_mode, .straps_valid);

//--- misc_pin_consts.vh
`ifndef MISC_PIN_CONSTS_VH
`define MISC_PIN_CONSTS_VH
// Port/lane configuration codes
`define PL_5P5L 2'h0
`define PL_6P6L 2'h1
`define PL_5P6L 2'h2
`define PL_DEFAULT 2'h1
// Operating mode codes
`define OPMODE_NORMAL 3'h0
// Two-wire timing: quarter bit period in ns, cycles at 40 ns
`define TW_QUARTER_NS 2500
`define CLK_PERIOD_NS 40
`define TW_QUARTER_CYC ((`TW_QUARTER_NS) / (`CLK_PERIOD_NS))
// Expander read address base (7-bit, low three bits index the expander)
`define EXP_ADDR_BASE 7'h20
`endif

//--- strap_and_misc_pin_control.v
// Summary of operation
// [R1] Hot-plug two-wire clock driven open-drain, shared by all expanders.
// [R2] Hot-plug two-wire data is open-drain bidirectional, shared by expanders.
// [R3] Low hot-plug interrupt starts reads of every expander's port registers.
// [R4] Expanders pull interrupt low on change, release after being read.
// [R5] Each GPIO pin is input-only or bidirectional per output enable bit.
// [R6] GPIO 1:0 strap gives port/lane config: 00 5/5, 01 6/6, 10 5/6.
// [R7] In debug mode GPIO 4:0 give the debug mode selection code.
// [R8] Five debug output pins show internal debug status during operation.
// [R9] Debug outputs 2:0 sampled at init as operating mode; zero is normal.
// [R10] Debug outputs 4 and 3 double as upstream select straps bits 1 and 0.
// [R11] Protocol-select pin high picks I2C, low picks SMBus.
// [R12] Test input low means normal mode; other test behaviour reserved.
// [R13] Upstream-port strap value chooses which switch port is upstream.
// [R14] All straps latched once at reset release, then held constant.
// [R15] Port/lane strap 11 is treated as the six-port six-lane default.
`timescale 1ns/1ns
`include "misc_pin_consts.vh"
module strap_and_misc_pin_control #(
    parameter NUM_EXP = 4,
    parameter QUARTER = `TW_QUARTER_CYC
) (
    input wire mclk,
    input wire rst_n,
    // Hot-plug two-wire master
    output reg hotplug_scl_out,
    output reg hotplug_scl_oe,
    input wire hotplug_scl_in,
    output reg hotplug_sda_out,
    output reg hotplug_sda_oe,
    input wire hotplug_sda_io,
    input wire hotplug_irq_n,
    output reg [7:0] exp_port_status,
    output reg [2:0] exp_status_idx,
    output reg exp_status_valid,
    output reg exp_nack,
    // General purpose pins
    input wire [7:0] gpio_in,
    output reg [7:0] gpio_out,
    output reg [7:0] gpio_oe,
    input wire [7:0] gpio_oe_ctrl,
    input wire [7:0] gpio_out_ctrl,
    output reg [7:0] gpio_in_value,
    // Debug pins, shared with straps
    input wire [4:0] debug_pin_in,
    output reg [4:0] debug_status_out,
    output reg [4:0] debug_status_oe,
    input wire [4:0] debug_status_int,
    input wire [1:0] upstream_port_strap_hi,
    input wire protocol_sel_in,
    input wire test_in,
    input wire [3:0] tie_high_straps,
    // Captured configuration
    output reg [1:0] port_lane_cfg,
    output reg [2:0] op_mode_strap,
    output reg [3:0] upstream_port_strap,
    output reg i2c_mode,
    output reg normal_mode,
    output reg debug_mode,
    output reg [4:0] debug_sel,
    output reg straps_valid
);
    // Three-stage synchronisers on every pin input
    reg [7:0] gp_s1, gp_s2, gp_s3;
    reg [4:0] db_s1, db_s2, db_s3;
    reg [1:0] up_s1, up_s2, up_s3;
    reg [2:0] misc_s1, misc_s2, misc_s3;
    reg irq_s1, irq_s2, irq_s3;
    reg sda_s1, sda_s2, sda_s3;
    reg scl_s1, scl_s2, scl_s3;
    reg [1:0] sync_cnt_q;
    reg strap_done_q;
    always @(posedge mclk)
    begin
        gp_s1 <= gpio_in;
        gp_s2 <= gp_s1;
        gp_s3 <= gp_s2;
        db_s1 <= debug_pin_in;
        db_s2 <= db_s1;
        db_s3 <= db_s2;
        up_s1 <= upstream_port_strap_hi;
        up_s2 <= up_s1;
        up_s3 <= up_s2;
        misc_s1 <= {protocol_sel_in, test_in, &tie_high_straps};
        misc_s2 <= misc_s1;
        misc_s3 <= misc_s2;
        irq_s1 <= hotplug_irq_n;
        irq_s2 <= irq_s1;
        irq_s3 <= irq_s2;
        sda_s1 <= hotplug_sda_io;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
        scl_s1 <= hotplug_scl_in;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
    end

    // Filtered levels: change accepted once stages two and three agree
    reg irq_f, sda_f;
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            irq_f <= 1'b1;
            sda_f <= 1'b1;
        end
        else
        begin
            if (irq_s2 == irq_s3)
                irq_f <= irq_s3;
            if (sda_s2 == sda_s3)
                sda_f <= sda_s3;
        end
    end

    // Per-bit GPIO filter: a bit holds while stages two and three disagree
    wire [7:0] gp_agree = ~(gp_s2 ^ gp_s3);
    wire [7:0] gp_f = (gp_agree & gp_s3) | (~gp_agree & gpio_in_value);

    // Strap capture: wait for the pipeline to fill after reset, latch once
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            port_lane_cfg <= `PL_DEFAULT;
            op_mode_strap <= `OPMODE_NORMAL;
            upstream_port_strap <= 4'h0;
            i2c_mode <= 1'b1;
            normal_mode <= 1'b1;
            straps_valid <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            if (sync_cnt_q != 2'h3)
                sync_cnt_q <= sync_cnt_q + 2'h1;
            else
            begin
                strap_done_q <= 1'b1; // [R14]
                straps_valid <= 1'b1;
                // Undefined 11 falls back to the default
                port_lane_cfg <= (gp_s3[1:0] == 2'h3) ? `PL_DEFAULT : gp_s3[1:0]; // [R6] [R15]
                op_mode_strap <= db_s3[2:0]; // [R9]
                upstream_port_strap <= {up_s3, db_s3[4], db_s3[3]}; // [R10] [R13]
                i2c_mode <= misc_s3[2]; // [R11]
                normal_mode <= ~misc_s3[1]; // [R12]
            end
        end
    end

    // Debug, GPIO and debug pin outputs; straps are released to input during capture
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            debug_mode <= 1'b0;
            debug_sel <= 5'h0;
            debug_status_out <= 5'h0;
            debug_status_oe <= 5'h0;
            gpio_out <= 8'h0;
            gpio_oe <= 8'h0;
            gpio_in_value <= 8'h0;
        end
        else
        begin
            debug_mode <= strap_done_q && (op_mode_strap != `OPMODE_NORMAL);
            if (debug_mode)
                debug_sel <= gp_f[4:0]; // [R7]
            debug_status_out <= debug_status_int; // [R8]
            debug_status_oe <= strap_done_q ? 5'h1f : 5'h0; // [R10]
            gpio_out <= gpio_out_ctrl;
            gpio_oe <= strap_done_q ? gpio_oe_ctrl : 8'h0; // [R5]
            gpio_in_value <= gp_f; // One cycle behind the raw third stage
        end
    end

    // Two-wire master: on interrupt, read one port byte from each expander
    localparam ST_IDLE = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_AACK = 3'h3;
    localparam ST_DATA = 3'h4;
    localparam ST_NACK = 3'h5;
    localparam ST_STOP = 3'h6;
    reg [2:0] state_q;
    reg [15:0] tick_q;
    reg [1:0] phase_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [2:0] exp_q;
    wire tick = (tick_q == QUARTER - 1);
    wire adv = tick && (phase_q == 2'h3);
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            tick_q <= 16'h0;
            phase_q <= 2'h0;
            bit_q <= 4'h0;
            shift_q <= 8'h0;
            exp_q <= 3'h0;
            hotplug_scl_out <= 1'b0;
            hotplug_scl_oe <= 1'b0;
            hotplug_sda_out <= 1'b0;
            hotplug_sda_oe <= 1'b0;
            exp_port_status <= 8'h0;
            exp_status_idx <= 3'h0;
            exp_status_valid <= 1'b0;
            exp_nack <= 1'b0;
        end
        else
        begin
            exp_status_valid <= 1'b0;
            tick_q <= (state_q == ST_IDLE || tick) ? 16'h0 : tick_q + 16'h1;
            if (tick)
                phase_q <= phase_q + 2'h1;
            // Clock low in phases 0 and 3, released in 1 and 2; open drain only pulls low
            if (state_q != ST_IDLE && state_q != ST_START && state_q != ST_STOP)
                hotplug_scl_oe <= (phase_q == 2'h0) || (phase_q == 2'h3); // [R1]
            else
                hotplug_scl_oe <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    phase_q <= 2'h0;
                    hotplug_sda_oe <= 1'b0;
                    // Interrupt held low after a pass restarts a fresh pass
                    if (strap_done_q && !irq_f) // [R3]
                    begin
                        state_q <= ST_START;
                        exp_q <= 3'h0;
                    end
                end
                ST_START:
                begin
                    if (tick && phase_q == 2'h1)
                        hotplug_sda_oe <= 1'b1; // [R2]
                    if (adv)
                    begin
                        state_q <= ST_ADDR;
                        shift_q <= {`EXP_ADDR_BASE | {4'h0, exp_q}, 1'b1};
                        bit_q <= 4'h0;
                    end
                end
                ST_ADDR:
                begin
                    hotplug_sda_oe <= ~shift_q[7]; // [R2]
                    if (adv)
                    begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7)
                            state_q <= ST_AACK;
                    end
                end
                ST_AACK:
                begin
                    hotplug_sda_oe <= 1'b0;
                    if (tick && phase_q == 2'h2 && sda_f)
                        exp_nack <= 1'b1; // Missing expander noted, pass goes on
                    if (adv)
                    begin
                        state_q <= ST_DATA;
                        bit_q <= 4'h0;
                    end
                end
                ST_DATA:
                begin
                    hotplug_sda_oe <= 1'b0;
                    if (tick && phase_q == 2'h2)
                        shift_q <= {shift_q[6:0], sda_f}; // [R3]
                    if (adv)
                    begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7)
                            state_q <= ST_NACK;
                    end
                end
                ST_NACK:
                begin
                    hotplug_sda_oe <= 1'b0; // Last byte: master does not acknowledge
                    if (adv)
                    begin
                        exp_port_status <= shift_q;
                        exp_status_idx <= exp_q;
                        exp_status_valid <= 1'b1;
                        state_q <= ST_STOP;
                        hotplug_sda_oe <= 1'b1;
                    end
                end
                ST_STOP:
                begin
                    if (tick && phase_q == 2'h2)
                        hotplug_sda_oe <= 1'b0;
                    if (adv)
                    begin
                        if (exp_q == NUM_EXP - 1)
                            state_q <= ST_IDLE; // [R4]
                        else
                        begin
                            exp_q <= exp_q + 3'h1;
                            state_q <= ST_START;
                        end
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // strap_and_misc_pin_control

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
    reg mclk = 1'b0, rst_n = 1'b0, protocol_sel_in = 1'b0, test_in = 1'b0;
    reg [7:0] gpio_ext = 8'h00, gpio_oe_ctrl = 8'h00, gpio_out_ctrl = 8'h00;
    reg [4:0] debug_pin_in = 5'h00, debug_status_int = 5'h00;
    reg [1:0] upstream_port_strap_hi = 2'h0;
    reg [3:0] tie_high_straps = 4'hf, change = 4'h0;
    wire hotplug_scl_out, hotplug_scl_oe, hotplug_sda_out, hotplug_sda_oe, hotplug_irq_n, pull;
    wire exp_status_valid, exp_nack, i2c_mode, normal_mode, debug_mode, straps_valid;
    wire [7:0] exp_port_status, gpio_out, gpio_oe, gpio_in_value;
    wire [4:0] debug_status_out, debug_status_oe, debug_sel;
    wire [2:0] exp_status_idx, op_mode_strap;
    wire [1:0] port_lane_cfg;
    wire [3:0] upstream_port_strap;
    // Wire levels: pull-ups on both two-wire lines, pads follow their enables
    wire hotplug_scl_in = !hotplug_scl_oe;
    wire hotplug_sda_io = !(hotplug_sda_oe || pull);
    wire [7:0] gpio_in = gpio_oe & gpio_out | ~gpio_oe & gpio_ext;
    integer err_count = 0, checks = 0, cycles = 0, vcount = 0, i, k;
    strap_and_misc_pin_control #(.NUM_EXP(4), .QUARTER(2)) DUT (.mclk, .rst_n,
        .hotplug_scl_out, .hotplug_scl_oe, .hotplug_scl_in, .hotplug_sda_out, .hotplug_sda_oe,
        .hotplug_sda_io, .hotplug_irq_n, .exp_port_status, .exp_status_idx, .exp_status_valid,
        .exp_nack, .gpio_in, .gpio_out, .gpio_oe, .gpio_oe_ctrl, .gpio_out_ctrl, .gpio_in_value,
        .debug_pin_in, .debug_status_out, .debug_status_oe, .debug_status_int,
        .upstream_port_strap_hi, .protocol_sel_in, .test_in, .tie_high_straps, .port_lane_cfg,
        .op_mode_strap, .upstream_port_strap, .i2c_mode, .normal_mode, .debug_mode, .debug_sel,
        .straps_valid);
    exp_model #(.N(4)) partner (.scl(hotplug_scl_in), .sda(hotplug_sda_io), .change(change),
        .sda_pull(pull), .irq_n(hotplug_irq_n));
    // Clock and hang guard
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] want);
        begin
            checks = checks + 1;
            if (seen !== want)
            begin
                err_count = err_count + 1;
                $display("unexpected at %0t: saw %h want %h", $time, seen, want);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge mclk);
    endtask
    // Status pulses must come in expander order, each with that expander's byte
    // Sampled mid-cycle so the one-cycle pulse is read while it stands
    always @(negedge mclk)
        if (exp_status_valid === 1'b1)
        begin
            chk(exp_status_idx, vcount);
            chk(exp_port_status, 8'h5a ^ vcount);
            vcount = vcount + 1;
        end
    // Reset with one strap set, then move every strap pin except tie_high_straps; captured values must stay
    task strap_run(input integer n);
        begin
            rst_n = 1'b0;
            gpio_ext = n;
            debug_pin_in = {n[0], ~n[0], n == 3 ? 3'h5 : 3'h0};
            upstream_port_strap_hi = 2'h3 ^ n[1:0];
            protocol_sel_in = n[0];
            test_in = (n == 3);
            cyc(12);
            rst_n = 1'b1;
            for (k = 0; k < 20 && straps_valid !== 1'b1; k = k + 1) cyc(1);
            chk(k, 4);
            chk(straps_valid, 1);
            gpio_ext = 8'hf3 ^ n;
            debug_pin_in = ~debug_pin_in;
            upstream_port_strap_hi = ~upstream_port_strap_hi;
            protocol_sel_in = ~protocol_sel_in;
            test_in = ~test_in;
            cyc(8);
            chk(port_lane_cfg, n == 3 ? 1 : n);
            chk(op_mode_strap, n == 3 ? 5 : 0);
            chk(upstream_port_strap, {2'h3 ^ n[1:0], n[0], ~n[0]});
            chk(i2c_mode, n[0]);
            chk(debug_mode, n == 3);
            chk(normal_mode, n != 3);
            if (n == 3) chk(debug_sel, 5'h13 ^ n);
            $display("strap test %0d done", n);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, err_count);
            if (err_count == 0 && checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // Main sequence
    initial
    begin
        for (i = 0; i < 4; i = i + 1) strap_run(i);
        gpio_oe_ctrl = 8'h0f;
        gpio_out_ctrl = 8'ha5;
        gpio_ext = 8'h3c;
        debug_status_int = 5'h16;
        cyc(10);
        chk(gpio_oe, 8'h0f);
        chk(gpio_out, 8'ha5);
        chk(gpio_in_value, 8'h35);
        chk(debug_status_out, 5'h16);
        chk(debug_status_oe, 5'h1f);
        gpio_oe_ctrl = 8'hf0;
        cyc(10);
        chk(gpio_in_value, 8'hac);
        $display("gpio and debug test done");
        change = 4'ha;
        cyc(1);
        change = 4'h0;
        for (k = 0; k < 3000 && vcount < 4; k = k + 1) cyc(1);
        chk(hotplug_irq_n, 1);
        chk(exp_nack, 0);
        cyc(300);
        chk(vcount, 4);
        $display("hot-plug test done");
        tally_and_finish;
    end
endmodule // testbench
